// ---- logic/osc_ctrl_pkg.sv ----
// Package for the oscillator control and status block
package osc_ctrl_pkg;
    // Register byte addresses on APB
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_TUNING = 12'h008;
    localparam logic [11:0] ADDR_FAIL = 12'h00C;
    // Control register fields
    localparam int CTL_PLL_BIT = 7;
    localparam int CTL_FREQ_LSB = 3;
    localparam int CTL_SRC_LSB = 0;
    localparam logic [3:0] FREQ_SEL_RESET = 4'h7;
    localparam logic [7:0] CONTROL_RESET = 8'h38;
    localparam logic [7:0] CONTROL_MASK = 8'hFB;
    localparam logic [7:0] TUNING_MASK = 8'h3F;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    // Fail register fields
    localparam int FAIL_FLAG_BIT = 0;
    localparam int FAIL_IE_BIT = 1;
    // Start-up timer length in external clock cycles
    localparam int STARTUP_CYCLES = 1024;
    // Clock source codes
    localparam logic [1:0] SRC_CONFIG = 2'b00;
    localparam logic [1:0] SRC_TIMER1 = 2'b01;
    // Frequency source families
    typedef enum logic [2:0] {
        FAM_LF = 3'b001,
        FAM_MF = 3'b010,
        FAM_HF = 3'b100
    } freq_family_t;
    // Selected system clock
    typedef enum logic [3:0] {
        SEL_CONFIG = 4'b0001,
        SEL_TIMER1 = 4'b0010,
        SEL_INTERNAL = 4'b0100,
        SEL_PLL32 = 4'b1000
    } clk_route_t;
    // Start-up sequencer states
    typedef enum logic [2:0] {
        ST_INTERNAL = 3'b001,
        ST_COUNTING = 3'b010,
        ST_EXTERNAL = 3'b100
    } startup_state_t;
endpackage

// ---- logic/oscillator_control_status_regs.sv ----
// Oscillator control, status and tuning registers with start-up and fail-safe control
// Operation
// - Config PLL force set: multiplier always on whatever the software PLL enable, which still gates the 32 MHz route.
// - Config PLL force clear: software PLL enable bit turns multiplier on or off.
// - Codes 0111..0100, 0010 pick MF; 000x pick LF; reset loads 0111.
// - Codes 1010, 1001, 1000, 0011 derive duplicate frequencies from HF oscillator.
// - Codes 1111/1110 give 32 MHz when software PLL enable is set and the internal source would otherwise be routed.
// - Source select 1x internal, 01 Timer1, 00 configuration-word source.
// - Unimplemented control bit 2 and tuning bits 7:6 read zero.
// - Timer1 ready reflects oscillator when enabled, reads 1 when disabled.
// - Start-up status 1 once the start-up timer has expired with no clock fail, whatever the source select; 0 otherwise.
// - HF, MF, LF ready bits each show their oscillator ready.
// - HF locked bit shows oscillator within 2% accuracy.
// - HF stable bit shows oscillator within 0.5% accuracy.
// - Six-bit signed trim: 000000 nominal, 100000 minimum, 011111 maximum.
// - External clock fail moves clock to internal source, sets fail flag.
// - Start-up timer counts 1024 external cycles before switching to external.
// - Source select change restarts start-up timer; source 00 runs on internal clock until expiry, Timer1 (01) is routed at once.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module oscillator_control_status_regs #(
    parameter int STARTUP_COUNT = osc_ctrl_pkg::STARTUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_pll_force,
    input wire logic config_ext_mode,
    input wire logic timer1_osc_enable,
    input wire logic timer1_osc_ok,
    input wire logic pll_lock_ok,
    input wire logic hf_ok,
    input wire logic hf_lock2_ok,
    input wire logic mf_ok,
    input wire logic lf_ok,
    input wire logic hf_stable05_ok,
    input wire logic ext_clk_tick,
    input wire logic ext_clk_fail,
    output logic pll_enable,
    output logic [3:0] internal_freq_select,
    output logic [2:0] freq_family,
    output logic [5:0] freq_trim,
    output logic [3:0] sysclk_route,
    output logic osc_fail_irq
);
    logic [7:0] control_r;
    logic [7:0] control_nxt;
    logic [5:0] trim_r;
    logic [5:0] trim_nxt;
    logic fail_flag_r;
    logic fail_flag_nxt;
    logic fail_ie_r;
    logic fail_ie_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic rd_pend_r;
    logic rd_pend_nxt;
    osc_ctrl_pkg::startup_state_t st_r;
    osc_ctrl_pkg::startup_state_t st_nxt;
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic [1:0] src_prev_r;
    logic [1:0] src_prev_nxt;
    logic fail_mode_r;
    logic fail_mode_nxt;
    osc_ctrl_pkg::clk_route_t route;
    osc_ctrl_pkg::freq_family_t fam;
    logic wr;
    logic rd;
    logic [3:0] fsel;
    logic [1:0] src;
    logic ext_active;

    // Writes finish in their access cycle; reads take one wait state so that
    // read data comes from a flip-flop yet stands while pready is high
    assign pready = clk_en & (~rd | rd_pend_r);
    assign wr = psel & penable & pwrite & clk_en;
    assign rd = psel & penable & ~pwrite;
    assign fsel = control_r[osc_ctrl_pkg::CTL_FREQ_LSB +: 4];
    assign src = control_r[osc_ctrl_pkg::CTL_SRC_LSB +: 2];
    assign ext_active = (st_r == osc_ctrl_pkg::ST_EXTERNAL);
    assign internal_freq_select = fsel;
    assign freq_trim = trim_r;
    assign osc_fail_irq = fail_flag_r & fail_ie_r;
    assign prdata = prdata_r;
    assign freq_family = fam;
    assign sysclk_route = route;

    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable)
        begin
            pslverr = !(paddr == osc_ctrl_pkg::ADDR_CONTROL || paddr == osc_ctrl_pkg::ADDR_STATUS
                || paddr == osc_ctrl_pkg::ADDR_TUNING || paddr == osc_ctrl_pkg::ADDR_FAIL);
        end
    end

    // Read wait state: set by the first access cycle of a read, gone after the second
    // Frozen with the rest of the state while clk_en is low, so the wait just stretches
    always_comb
    begin
        rd_pend_nxt = 1'b0;
        if (rd && !rd_pend_r)
        begin
            rd_pend_nxt = 1'b1;
        end
    end

    // Multiplier enable
    always_comb
    begin
        pll_enable = config_pll_force | control_r[osc_ctrl_pkg::CTL_PLL_BIT];
    end

    // Family decode; duplicate HF codes keep HF so the MF oscillator can sleep
    always_comb
    begin
        fam = osc_ctrl_pkg::FAM_LF;
        if (fsel[3])
        begin
            fam = osc_ctrl_pkg::FAM_HF;
        end
        else if (fsel == 4'h3)
        begin
            fam = osc_ctrl_pkg::FAM_HF;
        end
        else if (fsel[2] || fsel == 4'h2)
        begin
            fam = osc_ctrl_pkg::FAM_MF;
        end
    end

    // Clock route: for source 00, fail-safe and unexpired start-up both hold the internal source
    always_comb
    begin
        route = osc_ctrl_pkg::SEL_INTERNAL;
        if (src == osc_ctrl_pkg::SRC_TIMER1)
        begin
            route = osc_ctrl_pkg::SEL_TIMER1;
        end
        else if (src == osc_ctrl_pkg::SRC_CONFIG && ext_active && !fail_mode_r)
        begin
            route = osc_ctrl_pkg::SEL_CONFIG;
        end
        if (route == osc_ctrl_pkg::SEL_INTERNAL && fsel[3:1] == 3'b111
            && control_r[osc_ctrl_pkg::CTL_PLL_BIT])
        begin
            route = osc_ctrl_pkg::SEL_PLL32;
        end
    end

    // Register writes
    always_comb
    begin
        control_nxt = control_r;
        trim_nxt = trim_r;
        fail_ie_nxt = fail_ie_r;
        fail_flag_nxt = fail_flag_r;
        if (wr && pstrb[0] && paddr == osc_ctrl_pkg::ADDR_CONTROL)
        begin
            control_nxt = pwdata[7:0] & osc_ctrl_pkg::CONTROL_MASK;
        end
        if (wr && pstrb[0] && paddr == osc_ctrl_pkg::ADDR_TUNING)
        begin
            trim_nxt = pwdata[5:0];
        end
        if (wr && pstrb[0] && paddr == osc_ctrl_pkg::ADDR_FAIL)
        begin
            fail_ie_nxt = pwdata[osc_ctrl_pkg::FAIL_IE_BIT];
            fail_flag_nxt = fail_flag_r & pwdata[osc_ctrl_pkg::FAIL_FLAG_BIT];
        end
        // Set beats a software clear in the same cycle
        if (ext_clk_fail && ext_active && src == osc_ctrl_pkg::SRC_CONFIG)
        begin
            fail_flag_nxt = 1'b1;
        end
    end

    // Start-up timer and fail-safe state
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        src_prev_nxt = src;
        fail_mode_nxt = fail_mode_r;
        if (ext_clk_fail && ext_active && src == osc_ctrl_pkg::SRC_CONFIG)
        begin
            fail_mode_nxt = 1'b1;
        end
        case (st_r)
            osc_ctrl_pkg::ST_INTERNAL:
            begin
                if (config_ext_mode)
                begin
                    st_nxt = osc_ctrl_pkg::ST_COUNTING;
                    cnt_nxt = '0;
                end
            end
            osc_ctrl_pkg::ST_COUNTING:
            begin
                if (ext_clk_tick)
                begin
                    cnt_nxt = cnt_r + 11'd1;
                    if (cnt_r == 11'(STARTUP_COUNT - 1))
                    begin
                        st_nxt = osc_ctrl_pkg::ST_EXTERNAL;
                        fail_mode_nxt = 1'b0;
                    end
                end
            end
            osc_ctrl_pkg::ST_EXTERNAL:
            begin
            end
            default:
            begin
                st_nxt = osc_ctrl_pkg::ST_INTERNAL;
            end
        endcase
        if (!config_ext_mode)
        begin
            st_nxt = osc_ctrl_pkg::ST_INTERNAL;
        end
        else if (src != src_prev_r)
        begin
            st_nxt = osc_ctrl_pkg::ST_COUNTING;
            cnt_nxt = '0;
        end
    end

    // Status snapshot, rebuilt every cycle from inputs and the start-up and fail-safe state
    always_comb
    begin
        status_nxt[7] = timer1_osc_enable ? timer1_osc_ok : 1'b1;
        status_nxt[6] = pll_lock_ok;
        status_nxt[5] = ext_active && !fail_mode_r;
        status_nxt[4] = hf_ok;
        status_nxt[3] = hf_lock2_ok;
        status_nxt[2] = mf_ok;
        status_nxt[1] = lf_ok;
        status_nxt[0] = hf_stable05_ok;
    end

    // Read data; the status register has no write path
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (rd && !rd_pend_r)
        begin
            case (paddr)
                osc_ctrl_pkg::ADDR_CONTROL: prdata_nxt = {24'h00_0000, control_r};
                osc_ctrl_pkg::ADDR_STATUS: prdata_nxt = {24'h00_0000, status_r};
                osc_ctrl_pkg::ADDR_TUNING: prdata_nxt = {26'h000_0000, trim_r};
                osc_ctrl_pkg::ADDR_FAIL: prdata_nxt = {30'h0000_0000, fail_ie_r, fail_flag_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            control_r <= osc_ctrl_pkg::CONTROL_RESET;
            trim_r <= osc_ctrl_pkg::TRIM_RESET;
            fail_flag_r <= 1'b0;
            fail_ie_r <= 1'b0;
            status_r <= 8'h00;
            prdata_r <= 32'h0000_0000;
            rd_pend_r <= 1'b0;
            st_r <= osc_ctrl_pkg::ST_INTERNAL;
            cnt_r <= 11'h000;
            src_prev_r <= osc_ctrl_pkg::SRC_CONFIG;
            fail_mode_r <= 1'b0;
        end
        else if (clk_en)
        begin
            control_r <= control_nxt;
            trim_r <= trim_nxt;
            fail_flag_r <= fail_flag_nxt;
            fail_ie_r <= fail_ie_nxt;
            status_r <= status_nxt;
            prdata_r <= prdata_nxt;
            rd_pend_r <= rd_pend_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            src_prev_r <= src_prev_nxt;
            fail_mode_r <= fail_mode_nxt;
        end
    end
endmodule

// ---- test/osc_regs_assertions.sv ----
// Checker for the oscillator control register block
`timescale 1ns/1ps
module osc_regs_assertions (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic config_pll_force,
    input wire logic pll_enable,
    input wire logic [3:0] internal_freq_select,
    input wire logic [2:0] freq_family,
    input wire logic [5:0] freq_trim,
    input wire logic [3:0] sysclk_route
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_ctl_wr;
        psel && penable && pwrite && clk_en && pstrb[0] && paddr == osc_ctrl_pkg::ADDR_CONTROL;
    endsequence
    a_pll_forced: assert property (config_pll_force |-> pll_enable)
        else $error("multiplier off while forced");
    a_pll_soft: assert property (s_ctl_wr ##1 !config_pll_force |-> pll_enable == $past(pwdata[7]))
        else $error("multiplier does not follow software bit");
    a_hf_family: assert property (internal_freq_select[3] || internal_freq_select == 4'h3
        |-> freq_family == 3'b100)
        else $error("code not on fast oscillator");
    a_mf_family: assert property (internal_freq_select inside {4'h2, [4'h4:4'h7]}
        |-> freq_family == 3'b010)
        else $error("code not on medium oscillator");
    a_lf_family: assert property (internal_freq_select[3:1] == 3'h0 |-> freq_family == 3'b001)
        else $error("code not on slow oscillator");
    a_reset_select: assert property ($fell(srst) |-> internal_freq_select == 4'h7)
        else $error("select not default after reset");
    a_pll32_cause: assert property (sysclk_route == 4'h8
        |-> internal_freq_select[3:1] == 3'h7 && pll_enable)
        else $error("doubled clock without cause");
    a_timer1_route: assert property (s_ctl_wr ##0 pwdata[1:0] == 2'b01 |=> sysclk_route == 4'h2)
        else $error("timer1 source not routed");
    a_trim_hold: assert property (!(psel && penable && pwrite && paddr == osc_ctrl_pkg::ADDR_TUNING)
        |=> $stable(freq_trim))
        else $error("trim changed without write");
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the oscillator control register block
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 0, srst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, v, seed = 77;
    logic [3:0] pstrb = 4'hF, internal_freq_select, sysclk_route;
    logic [7:0] st_in = 0;
    logic config_pll_force = 0, config_ext_mode = 1, ext_clk_tick = 0, ext_clk_fail = 0;
    logic pready, pslverr, err, pll_enable, osc_fail_irq;
    logic [2:0] freq_family;
    logic [5:0] freq_trim;
    int failures = 0, tests_run = 0;
    oscillator_control_status_regs #(.STARTUP_COUNT(8)) i_dut (.sys_clk, .srst, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .config_pll_force, .config_ext_mode, .timer1_osc_enable(st_in[5]),
        .timer1_osc_ok(st_in[7]), .pll_lock_ok(st_in[6]), .hf_ok(st_in[4]),
        .hf_lock2_ok(st_in[3]), .mf_ok(st_in[2]), .lf_ok(st_in[1]), .hf_stable05_ok(st_in[0]),
        .ext_clk_tick, .ext_clk_fail, .pll_enable, .internal_freq_select, .freq_family,
        .freq_trim, .sysclk_route, .osc_fail_irq);
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected clock route, source 00 left out since it depends on start-up state
    function automatic logic [31:0] route(input logic [7:0] c);
        if (c[1:0] == 2'b01)
            return 2;
        return (c[6:4] == 3'h7 && c[7]) ? 8 : 4;
    endfunction
    function automatic logic [31:0] fam(input logic [3:0] s);
        if (s[3:1] == 3'h0)
            return 1;
        return (s[3] || s == 4'h3) ? 4 : 2;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Holds the request until pready is high at a rising edge and takes the answer there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        while (!done)
        begin
            // Inputs move only on rising edges, so the falling edge shows what the next one samples
            @(negedge sys_clk);
            done = (pready === 1'b1);
            err = pslverr;
            rd = prdata;
            @(posedge sys_clk);
        end
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            ext_clk_tick <= 1;
            @(posedge sys_clk);
            ext_clk_tick <= 0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        apb(0, osc_ctrl_pkg::ADDR_CONTROL, 0);
        chk(rd, 32'h38);
        ticks(7);
        chk(32'(sysclk_route), 4);
        ticks(1);
        chk(32'(sysclk_route), 1);
        repeat (6)
        begin
            st_in <= 8'(xs());
            apb(1, osc_ctrl_pkg::ADDR_STATUS, xs());
            apb(0, osc_ctrl_pkg::ADDR_STATUS, 0);
            chk(rd, {st_in[5] ? st_in[7] : 1'b1, st_in[6], 1'b1, st_in[4:0]});
        end
        // A change of source restarts the count
        apb(1, osc_ctrl_pkg::ADDR_CONTROL, 32'h3A);
        apb(1, osc_ctrl_pkg::ADDR_CONTROL, 32'h38);
        apb(0, osc_ctrl_pkg::ADDR_STATUS, 0);
        chk(32'({rd[5], sysclk_route}), 4);
        ticks(8);
        chk(32'(sysclk_route), 1);
        ext_clk_fail <= 1;
        @(posedge sys_clk);
        ext_clk_fail <= 0;
        apb(0, osc_ctrl_pkg::ADDR_FAIL, 0);
        chk(32'({rd[0], sysclk_route}), 32'h14);
        apb(1, osc_ctrl_pkg::ADDR_FAIL, 3);
        chk(32'(osc_fail_irq), 1);
        apb(1, osc_ctrl_pkg::ADDR_FAIL, 2);
        chk(32'(osc_fail_irq), 0);
        for (int i = 0; i < 16; i++)
        begin
            v = xs();
            v[6:3] = i[3:0];
            v[1] = v[1] | ~v[0];
            apb(1, osc_ctrl_pkg::ADDR_CONTROL, v);
            apb(0, osc_ctrl_pkg::ADDR_CONTROL, 0);
            chk(rd, v & 32'hFB);
            chk({pll_enable, internal_freq_select}, v[7:3]);
            chk(32'(freq_family), fam(v[6:3]));
            chk(32'(sysclk_route), route(v[7:0]));
        end
        config_pll_force <= 1;
        apb(1, osc_ctrl_pkg::ADDR_CONTROL, 32'h2);
        chk(32'(pll_enable), 1);
        repeat (4)
        begin
            v = xs();
            apb(1, osc_ctrl_pkg::ADDR_TUNING, v);
            apb(0, osc_ctrl_pkg::ADDR_TUNING, 0);
            chk(32'(freq_trim), v & 32'h3F);
            chk(rd, v & 32'h3F);
        end
        apb(1, 12'h010, xs());
        apb(0, 12'h010, 0);
        chk(32'(err), 1);
        chk(rd, 0);
        tally_and_finish();
    end
endmodule
bind oscillator_control_status_regs osc_regs_assertions i_chk (.sys_clk, .srst, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .config_pll_force, .pll_enable,
    .internal_freq_select, .freq_family, .freq_trim, .sysclk_route);
